// file: hdl/fcrfe_regs.svh
// constants for the configuration reset front end
`ifndef FCRFE_REGS_SVH
`define FCRFE_REGS_SVH
`define FCRFE_CLK_MHZ 20
`define FCRFE_POR_TIME_NS 5000
`define FCRFE_POR_CYCLES ((`FCRFE_POR_TIME_NS * `FCRFE_CLK_MHZ + 999) / 1000)
`define FCRFE_MODE_SERIAL 2'h0
`define FCRFE_MODE_FAST 2'h2
`define FCRFE_MODE_ASYNC 2'h3
`define FCRFE_FIFO_DEPTH 16
`define FCRFE_STAGE_RESET_VAL 4'h1
`endif

// file: hdl/fcrfe_pkg.sv
// types for the configuration reset front end
package fcrfe_pkg;
	typedef enum logic [3:0] {
		FCRFE_ST_POR = 4'b0001,
		FCRFE_ST_RESET = 4'b0010,
		FCRFE_ST_CONFIG = 4'b0100,
		FCRFE_ST_INIT = 4'b1000
	} fcrfe_stage_t;
	typedef enum logic [2:0] {
		FCRFE_M_SERIAL = 3'b001,
		FCRFE_M_FAST = 3'b010,
		FCRFE_M_ASYNC = 3'b100
	} fcrfe_mode_t;
endpackage : fcrfe_pkg

// file: hdl/fcrfe_stream_if.sv
// valid/ready stream between the front end and its fifo
`timescale 1ns/1ps
interface fcrfe_stream_if #(parameter int W = 1);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : fcrfe_stream_if

// file: hdl/fcrfe_fifo.sv
// parameterised fifo with valid and ready on both sides
`timescale 1ns/1ps
module fcrfe_fifo #(
	parameter int W = 1,
	parameter int D = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	fcrfe_stream_if.snk s_in,
	fcrfe_stream_if.src s_out
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fcrfe_fifo_st_t;
	fcrfe_fifo_st_t st_ff;
	fcrfe_fifo_st_t nxt_st;
	logic [W-1:0] mem [D];
	logic push;
	logic pop;

	assign s_in.ready = (st_ff.cnt != (AW+1)'(D));
	assign s_out.valid = (st_ff.cnt != '0);
	assign s_out.data = mem[st_ff.rd];
	assign push = s_in.valid && s_in.ready;
	assign pop = s_out.valid && s_out.ready;

	always_comb
	begin
		nxt_st = st_ff;
		if (push)
			nxt_st.wr = st_ff.wr + AW'(1);
		if (pop)
			nxt_st.rd = st_ff.rd + AW'(1);
		if (push && !pop)
			nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
		else if (pop && !push)
			nxt_st.cnt = st_ff.cnt - (AW+1)'(1);
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
		if (push)
			mem[st_ff.wr] <= s_in.data;
	end

	a_fifo_no_overrun: assert property (@(posedge i_sys_clk) // R15
		disable iff (!i_reset_n) st_ff.cnt <= (AW+1)'(D))
		else $error("fifo count above depth");
endmodule : fcrfe_fifo

// file: hdl/fcrfe_top.sv
// configuration reset front end: scheme decode, por and reset stage
//----------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------
// Summary of operation
// R1 - decode mode_sel: 00 serial, 10 fast, 11 async
// R2 - jtag request overrides and ignores mode_sel
// R3 - mode_sel ignored in user mode
// R4 - internal power-on reset about 5 us
// R5 - during por hold status low, io tristate
// R6 - config device applies its own por delay
// R7 - config device holds oe low during delay
// R8 - release status after por; node wired-and
// R9 - user io stay tristate until user mode
// R10 - weak pull-ups on before and during configuration
// R11 - rising cfg_start_n starts a configuration cycle
// R12 - stages run reset, configuration, initialization
// R13 - stay in reset while start or status low
// R14 - start line driven by config device or tied high
// R15 - capture serial_data_in on rising cfg_clock
// R16 - release cfg_complete after all data accepted
// R17 - two flip-flops on start and status inputs
`timescale 1ns/1ps
`include "fcrfe_regs.svh"
module fcrfe_top #(
	parameter int POR_CYCLES = `FCRFE_POR_CYCLES,
	parameter int FIFO_DEPTH = `FCRFE_FIFO_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_mode_sel_hi,
	input wire logic i_mode_sel_lo,
	input wire logic i_jtag_cfg_req,
	input wire logic i_cfg_start_n,
	input wire logic i_cfg_status_n,
	input wire logic i_cfg_clock,
	input wire logic i_serial_data_in,
	input wire logic i_cfg_complete,
	input wire logic i_load_done,
	input wire logic i_init_done,
	input wire logic i_bit_ready,
	output logic o_cfg_status_n_o,
	output logic o_cfg_status_n_oe,
	output logic o_cfg_complete_o,
	output logic o_cfg_complete_oe,
	output logic [3:0] o_stage,
	output logic [2:0] o_mode,
	output logic o_jtag_mode,
	output logic o_user_io_en,
	output logic o_weak_pullup_en,
	output logic o_bit_valid,
	output logic o_bit_data
);
	localparam int CW = $clog2(POR_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] por_cnt;
		fcrfe_pkg::fcrfe_stage_t stage;
		fcrfe_pkg::fcrfe_mode_t mode;
		logic jtag;
		logic [1:0] start_s;
		logic [1:0] status_s;
		logic [2:0] clk_s;
		logic [1:0] data_s;
		logic [1:0] msel_a;
		logic [1:0] msel_b;
		logic [1:0] jtag_s;
		logic start_prev;
		logic status_drive;
		logic done_drive;
		logic out_valid;
		logic out_data;
	} fcrfe_st_t;

	fcrfe_st_t st_ff;
	fcrfe_st_t nxt_st;
	logic start_rise;
	logic cfg_clk_rise;

	fcrfe_stream_if #(.W(1)) bit_in ();
	fcrfe_stream_if #(.W(1)) bit_out ();

	fcrfe_fifo #(
		.W(1),
		.D(FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.s_in(bit_in.snk),
		.s_out(bit_out.src)
	);

	//----------------------------------------------------------------
	// serial bit capture into the fifo
	//----------------------------------------------------------------
	// rising edge seen on synchronised stages only
	assign cfg_clk_rise = st_ff.clk_s[1] && !st_ff.clk_s[2]; // R15
	assign bit_in.valid = cfg_clk_rise &&
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_CONFIG); // R15
	assign bit_in.data = st_ff.data_s[1];
	// the output register is the fifo's drain; it stalls on i_bit_ready
	assign bit_out.ready = !st_ff.out_valid || i_bit_ready;
	assign start_rise = st_ff.start_s[1] && !st_ff.start_prev; // R11

	//----------------------------------------------------------------
	// next state
	//----------------------------------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		// synchronisers on the start, status, clock, data, mode_sel and jtag pin inputs
		nxt_st.start_s = {st_ff.start_s[0], i_cfg_start_n}; // R17
		nxt_st.status_s = {st_ff.status_s[0], i_cfg_status_n}; // R17
		nxt_st.clk_s = {st_ff.clk_s[1:0], i_cfg_clock};
		nxt_st.data_s = {st_ff.data_s[0], i_serial_data_in};
		nxt_st.msel_a = {i_mode_sel_hi, i_mode_sel_lo};
		nxt_st.msel_b = st_ff.msel_a;
		nxt_st.jtag_s = {st_ff.jtag_s[0], i_jtag_cfg_req};
		nxt_st.start_prev = st_ff.start_s[1];
		if (bit_out.ready)
		begin
			nxt_st.out_valid = bit_out.valid;
			nxt_st.out_data = bit_out.data;
		end
		case (st_ff.stage)
			fcrfe_pkg::FCRFE_ST_POR:
			begin
				nxt_st.status_drive = 1'b1; // R5
				if (st_ff.por_cnt == CW'(POR_CYCLES - 1))
				begin
					nxt_st.status_drive = 1'b0; // R8
					nxt_st.stage = fcrfe_pkg::FCRFE_ST_RESET;
				end
				else
					nxt_st.por_cnt = st_ff.por_cnt + CW'(1); // R4
			end
			fcrfe_pkg::FCRFE_ST_RESET:
			begin
				// scheme latched only here, never in user mode
				nxt_st.jtag = st_ff.jtag_s[1]; // R2
				case (st_ff.msel_b) // R1
					`FCRFE_MODE_FAST: nxt_st.mode = fcrfe_pkg::FCRFE_M_FAST;
					`FCRFE_MODE_ASYNC: nxt_st.mode = fcrfe_pkg::FCRFE_M_ASYNC;
					default: nxt_st.mode = fcrfe_pkg::FCRFE_M_SERIAL;
				endcase
				if (st_ff.jtag_s[1])
					nxt_st.mode = fcrfe_pkg::FCRFE_M_SERIAL; // R2
				nxt_st.done_drive = 1'b1;
				// both lines high; a start already high needs no new rise
				if (st_ff.start_s[1] && st_ff.status_s[1] &&
					(start_rise || st_ff.start_prev)) // R13
					nxt_st.stage = fcrfe_pkg::FCRFE_ST_CONFIG; // R12
			end
			fcrfe_pkg::FCRFE_ST_CONFIG:
			begin
				if (!st_ff.start_s[1] || !st_ff.status_s[1]) // R13
					nxt_st.stage = fcrfe_pkg::FCRFE_ST_RESET;
				else if (i_load_done)
				begin
					nxt_st.done_drive = 1'b0; // R16
					nxt_st.stage = fcrfe_pkg::FCRFE_ST_INIT; // R12
				end
			end
			fcrfe_pkg::FCRFE_ST_INIT:
			begin
				if (!st_ff.start_s[1]) // R13
				begin
					nxt_st.done_drive = 1'b1;
					nxt_st.stage = fcrfe_pkg::FCRFE_ST_RESET;
				end
			end
			default:
				nxt_st.stage = fcrfe_pkg::FCRFE_ST_POR;
		endcase
	end

	//----------------------------------------------------------------
	// state register and outputs
	//----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			st_ff <= '0;
			st_ff.stage <= fcrfe_pkg::FCRFE_ST_POR;
			st_ff.mode <= fcrfe_pkg::FCRFE_M_SERIAL;
			st_ff.status_drive <= 1'b1; // R5
			st_ff.done_drive <= 1'b1;
			st_ff.start_s <= 2'h0;
			st_ff.status_s <= 2'h0;
		end
		else
			st_ff <= nxt_st;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			o_cfg_status_n_o <= 1'b0;
			o_cfg_status_n_oe <= 1'b1;
			o_cfg_complete_o <= 1'b0;
			o_cfg_complete_oe <= 1'b1;
			o_stage <= `FCRFE_STAGE_RESET_VAL;
			o_mode <= 3'h1;
			o_jtag_mode <= 1'b0;
			o_user_io_en <= 1'b0;
			o_weak_pullup_en <= 1'b1;
			o_bit_valid <= 1'b0;
			o_bit_data <= 1'b0;
		end
		else
		begin
			o_cfg_status_n_o <= 1'b0;
			o_cfg_status_n_oe <= nxt_st.status_drive; // R8
			o_cfg_complete_o <= 1'b0;
			o_cfg_complete_oe <= nxt_st.done_drive; // R16
			o_stage <= nxt_st.stage;
			o_mode <= nxt_st.mode;
			o_jtag_mode <= nxt_st.jtag;
			// io enabled only once initialisation reports user mode
			o_user_io_en <= (nxt_st.stage == fcrfe_pkg::FCRFE_ST_INIT) &&
				i_init_done; // R9
			o_weak_pullup_en <= !((nxt_st.stage ==
				fcrfe_pkg::FCRFE_ST_INIT) && i_init_done); // R10
			o_bit_valid <= nxt_st.out_valid;
			o_bit_data <= nxt_st.out_data;
		end
	end

	//----------------------------------------------------------------
	// checks
	//----------------------------------------------------------------
	a_por_status_low: assert property (@(posedge i_sys_clk) // R5
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_POR) |-> o_cfg_status_n_oe)
		else $error("status not driven low during por");
	a_por_min_length: assert property (@(posedge i_sys_clk) // R4
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_RESET) &&
		$past(st_ff.stage == fcrfe_pkg::FCRFE_ST_POR) |->
		$past(st_ff.por_cnt) == CW'(POR_CYCLES - 1))
		else $error("por left early");
	a_reset_hold: assert property (@(posedge i_sys_clk) // R13
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_RESET) &&
		(!st_ff.start_s[1] || !st_ff.status_s[1]) |=>
		st_ff.stage == fcrfe_pkg::FCRFE_ST_RESET)
		else $error("left reset stage with a line low");
	a_stage_order: assert property (@(posedge i_sys_clk) // R12
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_INIT) |->
		$past(st_ff.stage) inside {fcrfe_pkg::FCRFE_ST_CONFIG,
		fcrfe_pkg::FCRFE_ST_INIT})
		else $error("initialisation entered out of order");
	a_mode_decode: assert property (@(posedge i_sys_clk) // R1
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_RESET) && !st_ff.jtag_s[1] &&
		(st_ff.msel_b == 2'h2) |=>
		st_ff.mode == fcrfe_pkg::FCRFE_M_FAST)
		else $error("mode decode wrong");
	a_jtag_priority: assert property (@(posedge i_sys_clk) // R2
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_RESET) && st_ff.jtag_s[1] |=>
		st_ff.jtag && st_ff.mode == fcrfe_pkg::FCRFE_M_SERIAL)
		else $error("jtag did not override mode pins");
	a_user_mode_stable: assert property (@(posedge i_sys_clk) // R3
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_INIT) &&
		$past(st_ff.stage == fcrfe_pkg::FCRFE_ST_INIT) |->
		$stable(st_ff.mode))
		else $error("mode changed in user mode");
	a_io_tristate: assert property (@(posedge i_sys_clk) // R9
		disable iff (!i_reset_n)
		(st_ff.stage != fcrfe_pkg::FCRFE_ST_INIT) |->
		!o_user_io_en && o_weak_pullup_en)
		else $error("user io enabled before user mode");
	a_bit_capture: assert property (@(posedge i_sys_clk) // R15
		disable iff (!i_reset_n)
		bit_in.valid && bit_in.ready |=>
		st_ff.stage != fcrfe_pkg::FCRFE_ST_POR)
		else $error("bit captured in por");
	a_sync_start: assert property (@(posedge i_sys_clk) // R17
		disable iff (!i_reset_n)
		1'b1 |=> st_ff.start_s[1] == $past(st_ff.start_s[0]))
		else $error("start synchroniser broken");
	a_done_release: assert property (@(posedge i_sys_clk) // R16
		disable iff (!i_reset_n)
		(st_ff.stage == fcrfe_pkg::FCRFE_ST_CONFIG) && i_load_done &&
		st_ff.start_s[1] && st_ff.status_s[1] |=> ##1 !o_cfg_complete_oe)
		else $error("complete line not released");
endmodule : fcrfe_top

// file: bench/fcrfe_cfgdev_model.sv
// behavioural serial configuration memory facing the front end
`timescale 1ns/1ps
module fcrfe_cfgdev_model #(
	parameter int DELAY = 120,
	parameter int HALF = 6
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_status_node,
	input wire logic i_select_n,
	input wire logic [31:0] i_word,
	input wire logic [5:0] i_nbits,
	output logic o_oe_low,
	output logic o_clk,
	output logic o_data
);
	int por_cnt;
	int ph;
	int sent;
	always @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			por_cnt <= 0;
			ph <= 0;
			sent <= 0;
			o_oe_low <= 1'b1;
			o_clk <= 1'b0;
			o_data <= 1'b1;
		end
		else if (por_cnt < DELAY)
			por_cnt <= por_cnt + 1;
		else
		begin
			o_oe_low <= 1'b0;
			if (i_select_n)
			begin
				o_clk <= 1'b0;
				o_data <= 1'b1;
			end
			else if (i_status_node && sent < i_nbits)
			begin
				ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
				if (ph == 0)
					o_data <= i_word[i_nbits - 1 - sent];
				if (ph == HALF)
					o_clk <= 1'b1;
				if (ph == 2 * HALF - 1)
				begin
					o_clk <= 1'b0;
					sent <= sent + 1;
				end
			end
			else
				o_data <= ~o_data;
		end
	end
endmodule : fcrfe_cfgdev_model

// file: bench/fcrfe_top_bench.sv
// self-checking bench for the configuration reset front end
`timescale 1ns/1ps
module fcrfe_top_bench;
	localparam int POR = 4;
	logic i_sys_clk, i_reset_n, i_mode_sel_hi, i_mode_sel_lo;
	logic i_jtag_cfg_req, i_cfg_start_n, i_load_done, i_init_done;
	logic i_bit_ready, i_cfg_status_n, i_cfg_clock, i_serial_data_in;
	logic i_cfg_complete, o_cfg_status_n_o, o_cfg_status_n_oe;
	logic o_cfg_complete_o, o_cfg_complete_oe, o_jtag_mode, o_user_io_en;
	logic o_weak_pullup_en, o_bit_valid, o_bit_data, oe_low;
	logic [3:0] o_stage;
	logic [2:0] o_mode;
	logic [31:0] word, rnd;
	logic [1:0] pins [3];
	logic [2:0] modes [3];
	logic q [$];
	int bad_count, n_checks;
	//----------------------------------------------------------------
	// wired nodes, design and partner
	//----------------------------------------------------------------
	assign i_cfg_status_n = (o_cfg_status_n_oe ? o_cfg_status_n_o : 1'b1)
		& ~oe_low;
	assign i_cfg_complete = o_cfg_complete_oe ? o_cfg_complete_o : 1'b1;
	fcrfe_top #(.POR_CYCLES(POR), .FIFO_DEPTH(16)) dut (.i_sys_clk,
		.i_reset_n, .i_mode_sel_hi, .i_mode_sel_lo, .i_jtag_cfg_req,
		.i_cfg_start_n, .i_cfg_status_n, .i_cfg_clock, .i_serial_data_in,
		.i_cfg_complete, .i_load_done, .i_init_done, .i_bit_ready,
		.o_cfg_status_n_o, .o_cfg_status_n_oe, .o_cfg_complete_o,
		.o_cfg_complete_oe, .o_stage, .o_mode, .o_jtag_mode, .o_user_io_en,
		.o_weak_pullup_en, .o_bit_valid, .o_bit_data);
	fcrfe_cfgdev_model partner (.i_sys_clk, .i_reset_n,
		.i_status_node(i_cfg_status_n), .i_select_n(i_cfg_complete),
		.i_word(word), .i_nbits(6'h14), .o_oe_low(oe_low),
		.o_clk(i_cfg_clock), .o_data(i_serial_data_in));
	//----------------------------------------------------------------
	// helpers
	//----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask : tick
	task automatic wait_stage(input logic [3:0] st, input int lim);
		int k;
		k = 0;
		while (o_stage !== st && k < lim)
		begin
			tick(1);
			k++;
		end
		check("stage", o_stage, st);
	endtask : wait_stage
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	//----------------------------------------------------------------
	// clock, watchdog and bit monitor
	//----------------------------------------------------------------
	initial
	begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	initial
	begin
		tick(4000);
		bad_count++;
		close_out();
	end
	always @(posedge i_sys_clk)
		if (o_bit_valid === 1'b1 && i_bit_ready === 1'b1)
		begin
			if (q.size() == 0)
				check("extra bit", 32'h0000_0001, 32'h0000_0000);
			else
				check("bit", o_bit_data, q.pop_front());
		end
	//----------------------------------------------------------------
	// stimulus
	//----------------------------------------------------------------
	initial
	begin
		pins = '{2'h2, 2'h3, 2'h0};
		modes = '{fcrfe_pkg::FCRFE_M_FAST, fcrfe_pkg::FCRFE_M_ASYNC,
			fcrfe_pkg::FCRFE_M_SERIAL};
		{i_reset_n, i_mode_sel_hi, i_mode_sel_lo, i_jtag_cfg_req} = 4'h0;
		{i_cfg_start_n, i_load_done, i_init_done, i_bit_ready} = 4'h0;
		rnd = xs(32'h0000_AB89);
		word = rnd;
		// output register plus a full fifo keep the first seventeen bits
		for (int i = 19; i >= 3; i--)
			q.push_back(word[i]);
		tick(2);
		i_reset_n <= 1'b1;
		tick(1);
		check("stage", o_stage, fcrfe_pkg::FCRFE_ST_POR);
		check("status oe", o_cfg_status_n_oe, 1);
		check("status o", o_cfg_status_n_o, 0);
		check("io en", o_user_io_en, 0);
		check("pullup", o_weak_pullup_en, 1);
		tick(POR - 2);
		check("stage", o_stage, fcrfe_pkg::FCRFE_ST_POR);
		wait_stage(fcrfe_pkg::FCRFE_ST_RESET, 10);
		tick(1);
		check("status oe", o_cfg_status_n_oe, 0);
		$display("power-on test done");
		for (int i = 0; i < 3; i++)
		begin
			{i_mode_sel_hi, i_mode_sel_lo} <= pins[i];
			tick(4);
			check("mode", o_mode, modes[i]);
		end
		i_jtag_cfg_req <= 1'b1;
		{i_mode_sel_hi, i_mode_sel_lo} <= 2'h2;
		tick(4);
		check("jtag", o_jtag_mode, 1);
		check("mode", o_mode, fcrfe_pkg::FCRFE_M_SERIAL);
		i_jtag_cfg_req <= 1'b0;
		{i_mode_sel_hi, i_mode_sel_lo} <= 2'h0;
		$display("mode test done");
		i_cfg_start_n <= 1'b1;
		tick(10);
		check("stage", o_stage, fcrfe_pkg::FCRFE_ST_RESET);
		wait_stage(fcrfe_pkg::FCRFE_ST_CONFIG, 200);
		check("io en", o_user_io_en, 0);
		check("pullup", o_weak_pullup_en, 1);
		{i_mode_sel_hi, i_mode_sel_lo} <= 2'h3;
		tick(4);
		check("mode", o_mode, fcrfe_pkg::FCRFE_M_SERIAL);
		for (int k = 0; k < 400 && partner.sent < 20; k++)
			tick(1);
		tick(8);
		for (int k = 0; k < 400 && q.size() > 0; k++)
		begin
			rnd = xs(rnd);
			i_bit_ready <= rnd[0];
			tick(1);
		end
		i_bit_ready <= 1'b1;
		tick(8);
		check("bits left", q.size(), 0);
		$display("stream test done");
		i_load_done <= 1'b1;
		wait_stage(fcrfe_pkg::FCRFE_ST_INIT, 10);
		tick(1);
		check("complete oe", o_cfg_complete_oe, 0);
		check("complete o", o_cfg_complete_o, 0);
		check("complete node", i_cfg_complete, 1);
		i_init_done <= 1'b1;
		tick(4);
		check("io en", o_user_io_en, 1);
		check("pullup", o_weak_pullup_en, 0);
		{i_mode_sel_hi, i_mode_sel_lo} <= 2'h2;
		tick(4);
		check("mode", o_mode, fcrfe_pkg::FCRFE_M_SERIAL);
		$display("user mode test done");
		close_out();
	end
endmodule : fcrfe_top_bench
